// ---- sim/codec_ctrl_props.sv ----
`timescale 1ns/10ps

// watches the decoded gain and mute outputs against apb writes
module codec_ctrl_props
   import codec_ctrl_pkg::*;
#(
   parameter int FIFO_DEPTH = 8
)
(
   input wire logic              pclk,
   input wire logic              presetn,
   input wire logic              psel,
   input wire logic              penable,
   input wire logic              pwrite,
   input wire logic [7:0]        paddr,
   input wire logic [31:0]       pwdata,
   input wire logic              pready,
   input wire logic signed [7:0] tx_amp2_gain_half_db,
   input wire logic signed [7:0] tx_pga_gain_half_db,
   input wire logic signed [7:0] tx_total_gain_half_db,
   input wire logic [7:0]        tx_mute_atten_db,
   input wire logic signed [7:0] rx_pga_gain_db,
   input wire logic signed [7:0] sidetone_gain_db,
   input wire logic signed [7:0] volume_gain_db,
   input wire logic              microphone_mute,
   input wire logic              sidetone_mute,
   input wire logic              earphone_mute,
   input wire logic              diff_earphone_amp_en,
   input wire logic              single_earphone_amp_en
);
   logic wr_any;

   // a write completes at this edge
   assign wr_any = psel && penable && pwrite && pready;

   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   chk_reset_defaults: assert property ($rose(presetn) |->
      int'(tx_total_gain_half_db) == 47 && int'(rx_pga_gain_db) == -1 && int'(sidetone_gain_db)
      == -12 && int'(volume_gain_db) == 0 && !microphone_mute && single_earphone_amp_en)
      else $error("outputs not at defaults after reset");
   chk_mic_atten: assert property (
      tx_mute_atten_db == (microphone_mute ? MIC_MUTE_ATTEN_DB : 8'h00))
      else $error("mute attenuation does not follow microphone mute");
   chk_amp_onehot: assert property (diff_earphone_amp_en ^ single_earphone_amp_en)
      else $error("earphone amplifier enables not exclusive");
   chk_pwr_flags: assert property (wr_any && paddr == PWR_OFS |-> ##2
      microphone_mute == $past(pwdata[MIC_MUTE_BIT], 2)
      && sidetone_mute == $past(pwdata[SIDETONE_MUTE_BIT], 2)
      && earphone_mute == $past(pwdata[EAR_MUTE_BIT], 2)
      && diff_earphone_amp_en == $past(pwdata[EAR_SEL_BIT], 2))
      else $error("power control flags wrong after write");
   chk_pwr_hold: assert property (wr_any && paddr == PWR_OFS |-> ##1
      $stable({microphone_mute, sidetone_mute, earphone_mute, diff_earphone_amp_en}))
      else $error("power control flags changed before storage");
   chk_tx_code: assert property (wr_any && paddr == TX_GAIN_OFS && pwdata[2:0] <= 3'h5
      |-> ##2 int'(tx_pga_gain_half_db) == -4 * int'($past(pwdata[2:0], 2))
      && int'(tx_amp2_gain_half_db) == ($past(pwdata[3], 2) ? 0 : 24))
      else $error("transmit gain decode wrong");
   chk_tx_total: assert property (tx_total_gain_half_db ==
      MIC_AMP1_HALF_DB + tx_amp2_gain_half_db + tx_pga_gain_half_db)
      else $error("transmit total is not the stage sum");
   chk_rx_code: assert property (wr_any && paddr == RX_GAIN_OFS && pwdata[3:0] <= 4'hc
      |-> ##2 int'(rx_pga_gain_db) == 6 - int'($past(pwdata[3:0], 2)))
      else $error("receive gain decode wrong");
   chk_side_code: assert property (wr_any && paddr == SIDE_OFS && pwdata[2:0] <= 3'h6
      |-> ##2 int'(sidetone_gain_db) == -12 - 2 * int'($past(pwdata[2:0], 2)))
      else $error("sidetone gain decode wrong");
   chk_vol_code: assert property (wr_any && paddr == VOLUME_OFS && pwdata[3:0] <= 4'h9
      |-> ##2 int'(volume_gain_db) == -2 * int'($past(pwdata[3:0], 2)))
      else $error("volume decode wrong");
endmodule // codec_ctrl_props

bind voice_codec_gain_mute_control codec_ctrl_props #(.FIFO_DEPTH(FIFO_DEPTH)) i_codec_ctrl_props
(
   .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
   .paddr(paddr), .pwdata(pwdata), .pready(pready),
   .tx_amp2_gain_half_db(tx_amp2_gain_half_db), .tx_pga_gain_half_db(tx_pga_gain_half_db),
   .tx_total_gain_half_db(tx_total_gain_half_db), .tx_mute_atten_db(tx_mute_atten_db),
   .rx_pga_gain_db(rx_pga_gain_db), .sidetone_gain_db(sidetone_gain_db),
   .volume_gain_db(volume_gain_db), .microphone_mute(microphone_mute),
   .sidetone_mute(sidetone_mute), .earphone_mute(earphone_mute),
   .diff_earphone_amp_en(diff_earphone_amp_en), .single_earphone_amp_en(single_earphone_amp_en)
);

// ---- sim/rx_word_sender.sv ----
`timescale 1ns/10ps

// sample-serial host: sends received words, bit clock idle low between frames
module rx_word_sender
(
   input wire logic pclk,
   output logic     rx_bit_clk,
   output logic     rx_frame_sync,
   output logic     rx_serial_data
);
   initial
   begin
      rx_bit_clk = 1'b0;
      rx_frame_sync = 1'b0;
      rx_serial_data = 1'b0;
   end

   // one word, half is the bit clock half period in pclk cycles (slow or prompt)
   task automatic send_word(input logic [14:0] word, input int len, input int half);
      for (int i = len - 1; i >= 0; i--)
      begin
         @(posedge pclk);
         rx_bit_clk <= 1'b1;
         rx_frame_sync <= (i == len - 1); // sync marks the first bit
         rx_serial_data <= word[i]; // msb first
         repeat (half) @(posedge pclk);
         rx_bit_clk <= 1'b0;
         repeat (half) @(posedge pclk);
      end
      rx_frame_sync <= 1'b0;
      rx_serial_data <= ~word[0]; // released line shows no stale bit
   endtask
endmodule // rx_word_sender

// ---- sim/voice_codec_gain_mute_control_tb.sv ----
`timescale 1ns/10ps

module voice_codec_gain_mute_control_tb;
   import codec_ctrl_pkg::*;

   logic pclk = 1'b0;
   logic presetn, psel, penable, pwrite, pready, pslverr, sample_ready;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata;
   logic rx_bit_clk, rx_frame_sync, rx_serial_data, sample_valid;
   logic [14:0] sample_word;
   logic signed [7:0] amp2, pga, total, rxg, side, vol;
   logic [7:0] atten;
   logic mic_m, side_m, ear_m, diff_en, single_en, linear_mode, power_up;
   int n_fail = 0;
   int n_tests = 0;
   int cycles = 0;

   // 125 MHz clock
   always #4 pclk = ~pclk;

   voice_codec_gain_mute_control #(.FIFO_DEPTH(8)) i_voice_codec_gain_mute_control
   (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .rx_bit_clk(rx_bit_clk), .rx_frame_sync(rx_frame_sync), .rx_serial_data(rx_serial_data),
      .sample_word(sample_word), .sample_valid(sample_valid), .sample_ready(sample_ready),
      .tx_amp2_gain_half_db(amp2), .tx_pga_gain_half_db(pga), .tx_total_gain_half_db(total),
      .tx_mute_atten_db(atten), .rx_pga_gain_db(rxg), .sidetone_gain_db(side),
      .volume_gain_db(vol), .microphone_mute(mic_m), .sidetone_mute(side_m),
      .earphone_mute(ear_m), .diff_earphone_amp_en(diff_en),
      .single_earphone_amp_en(single_en), .linear_mode(linear_mode), .power_up(power_up)
   );

   rx_word_sender i_rx_word_sender
   (
      .pclk(pclk), .rx_bit_clk(rx_bit_clk), .rx_frame_sync(rx_frame_sync),
      .rx_serial_data(rx_serial_data)
   );

   // report and end the run
   task automatic tally_and_finish();
      $display("comparisons %0d mismatches %0d", n_tests, n_fail);
      if (n_fail == 0 && n_tests > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp)
      begin
         n_fail++;
         $display("unexpected at %0t: got %h expected %h", $time, seen, exp);
      end
   endtask

   // one apb transfer, holds until pready is seen high
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] rd, output logic er);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      // pready high ends this wait; the hang guard ends it if pready never rises
      while (pready !== 1'b1)
         @(posedge pclk);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask

   // write, then let the decoded outputs land
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] rd;
      logic er;
      apb(1'b1, a, d, rd, er);
      @(posedge pclk);
   endtask

   // wait for a sample, compare it, pop it
   task automatic take(input logic [14:0] exp);
      while (sample_valid !== 1'b1)
         @(posedge pclk);
      check(sample_word, exp);
      sample_ready <= 1'b1;
      @(posedge pclk);
      sample_ready <= 1'b0;
      @(posedge pclk);
   endtask

   // hang guard
   always @(posedge pclk)
   begin
      cycles++;
      if (cycles == 20000)
      begin
         n_fail++;
         tally_and_finish();
      end
   end

   initial
   begin
      logic [31:0] rd;
      logic er;
      static logic [7:0] pv [6] = '{8'h40, 8'h80, 8'h08, 8'h02, 8'h01, 8'h00};
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
      sample_ready = 1'b0;
      repeat (16) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      // defaults after reset
      check(total, 47);
      check(rxg, -1);
      check(side, -12);
      check(vol, 0);
      check({mic_m, side_m, ear_m, diff_en, single_en}, 32'h1);
      apb(1'b0, TX_GAIN_OFS, 0, rd, er);
      check(rd, 32'h8);
      apb(1'b0, RX_GAIN_OFS, 0, rd, er);
      check(rd, 32'h7);
      // every documented code of each gain field
      for (int c = 0; c < 14; c++)
      begin
         if (c == 6 || c == 7)
            continue;
         wr(TX_GAIN_OFS, c);
         check(pga, -4 * (c % 8));
         check(amp2, c < 8 ? 24 : 0);
         check(total, 47 + (c < 8 ? 24 : 0) - 4 * (c % 8));
      end
      for (int c = 0; c < 13; c++)
      begin
         wr(RX_GAIN_OFS, c);
         check(rxg, 6 - c);
         if (c < 7)
         begin
            wr(SIDE_OFS, c);
            check(side, -12 - 2 * c);
         end
         if (c < 10)
         begin
            wr(VOLUME_OFS, c);
            check(vol, -2 * c);
         end
      end
      // mute and amplifier select bits, sidetone code left at 6
      foreach (pv[i])
      begin
         wr(PWR_OFS, pv[i]);
         check({mic_m, side_m, ear_m}, {pv[i][6], pv[i][7], pv[i][3]});
         check(atten, pv[i][6] ? 80 : 0);
         check({diff_en, single_en}, {pv[i][1], ~pv[i][1]});
         check(power_up, pv[i][0]);
         check(side, -24);
      end
      // unmapped address is refused
      apb(1'b0, 8'h20, 0, rd, er);
      check(er, 1);
      check(rd, 32'h0);
      // fill the fifo past full with the consumer stalled, then drain
      wr(MODE_OFS, 0);
      check(linear_mode, 0);
      for (int i = 0; i < 10; i++)
         i_rx_word_sender.send_word({7'h0, 4'(i), 4'(~i)}, COMPANDED_LEN, 2);
      repeat (4) @(posedge pclk);
      apb(1'b0, STATUS_OFS, 0, rd, er);
      check(rd, 32'h81);
      for (int i = 0; i < 10; i++)
         if (i != 8)
            take({7'h0, 4'(i), 4'(~i)});
      wr(STATUS_OFS, 1);
      apb(1'b0, STATUS_OFS, 0, rd, er);
      check(rd, 32'h0);
      // linear word with a slow bit clock
      wr(MODE_OFS, 1);
      check(linear_mode, 1);
      i_rx_word_sender.send_word(15'h4d39, LINEAR_LEN, 4);
      take(15'h4d39);
      apb(1'b0, SAMPLE_OFS, 0, rd, er);
      check(rd, 32'h4d39);
      // reset in mid-run brings every changed setting back to its default
      presetn <= 1'b0;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      check({total, rxg, side, vol}, 32'h2ffff400);
      check({mic_m, side_m, ear_m, diff_en, single_en, linear_mode, power_up}, 32'h4);
      apb(1'b0, TX_GAIN_OFS, 0, rd, er);
      check(rd, 32'h8);
      tally_and_finish();
   end
endmodule // voice_codec_gain_mute_control_tb

// ---- src/codec_ctrl_pkg.sv ----
package codec_ctrl_pkg;

   // register offsets, byte addresses on the apb bus
   localparam logic [7:0] PWR_OFS     = 8'h00;
   localparam logic [7:0] TX_GAIN_OFS = 8'h04;
   localparam logic [7:0] RX_GAIN_OFS = 8'h08;
   localparam logic [7:0] SIDE_OFS    = 8'h0c;
   localparam logic [7:0] VOLUME_OFS  = 8'h10;
   localparam logic [7:0] MODE_OFS    = 8'h14;
   localparam logic [7:0] STATUS_OFS  = 8'h18;
   localparam logic [7:0] SAMPLE_OFS  = 8'h1c;

   // power control field positions
   localparam int PWR_UP_BIT        = 0;
   localparam int EAR_SEL_BIT       = 1;
   localparam int EAR_MUTE_BIT      = 3;
   localparam int MIC_MUTE_BIT      = 6;
   localparam int SIDETONE_MUTE_BIT = 7;

   // mode and status field positions
   localparam int LINEAR_BIT        = 0;
   localparam int OVERRUN_BIT       = 0;
   localparam int BUSY_BIT          = 1;
   localparam int LEVEL_LSB         = 4;

   // reset values
   localparam logic [7:0] PWR_RST     = 8'h00;
   localparam logic [3:0] TX_GAIN_RST = 4'h8;
   localparam logic [3:0] RX_GAIN_RST = 4'h7;
   localparam logic [2:0] SIDE_RST    = 3'h0;
   localparam logic [3:0] VOLUME_RST  = 4'h0;
   localparam logic       LINEAR_RST  = 1'b0;

   // received sample word lengths
   localparam int COMPANDED_LEN = 8;
   localparam int LINEAR_LEN    = 15;

   // fixed analog gains in half-db units, mute attenuation in db
   localparam logic signed [7:0] MIC_AMP1_HALF_DB = 8'sh2f;
   localparam logic signed [7:0] MIC_AMP2_EXT_HALF_DB = 8'sh18;
   localparam logic [7:0] MIC_MUTE_ATTEN_DB = 8'h50;

   // receive shifter states
   typedef enum logic [1:0] {
      RX_IDLE  = 2'b01,
      RX_SHIFT = 2'b10
   } rx_state_type;

endpackage

// ---- src/voice_codec_gain_mute_control.sv ----
// Overview of operation
// - microphone mute bit 6 of power control mutes transmit path, 80 dB attenuation.
// - transmit code 0-5 extended (amp2 12 dB), 8-13 normal; pga 0 to -10 in 2 dB steps.
// - after reset transmit total gain is 23.5 dB, normal mode, no attenuation.
// - receive gain code 0 is +6 dB, minus 1 dB per step, code 12 is -6 dB.
// - after reset receive gain code is 0111, -1 dB.
// - sidetone code 0 is -12 dB, minus 2 dB per step, code 6 is -24 dB.
// - power control bit 7 mutes sidetone whatever its gain code.
// - after reset sidetone code is 000, -12 dB.
// - volume code 0 is 0 dB, minus 2 dB per step, code 9 is -18 dB.
// - after reset volume code is 0000, 0 dB.
// - power control bit 3 mutes the earphone output.
// - companded received words are 8 bits, most significant bit first.
// - linear received words are 15 bits, most significant bit first.
// - receive signal drives exactly one earphone amplifier.
// - power control bit 1 high picks differential, low picks single-ended amplifier.
// - active-low reset returns every control register to its default.
`timescale 1ns/10ps

// sample word fifo in flip-flops
module sample_fifo
#(
   parameter int WIDTH = 15,
   parameter int DEPTH = 8
)
(
   input  wire logic                       pclk,
   input  wire logic                       presetn,
   input  wire logic                       in_valid,
   output logic                            in_ready,
   input  wire logic [WIDTH-1:0]           in_data,
   output logic                            out_valid,
   input  wire logic                       out_ready,
   output logic [WIDTH-1:0]                out_data,
   output logic [$clog2(DEPTH+1)-1:0]      level
);
   localparam int PW = $clog2(DEPTH);
   localparam int LW = $clog2(DEPTH+1);
   localparam logic [PW-1:0] LAST = PW'(DEPTH-1);
   localparam logic [LW-1:0] FULL = LW'(DEPTH);

   logic [WIDTH-1:0] mem_r [DEPTH];
   logic [PW-1:0]    wr_ptr_r;
   logic [PW-1:0]    rd_ptr_r;
   logic [LW-1:0]    count_r;
   logic             push;
   logic             pop;

   generate
      if (DEPTH < 2 || WIDTH < 1)
      begin : bad_geometry
         $error("sample_fifo needs depth of two or more");
      end
   endgenerate

   // handshakes from the occupancy count
   assign in_ready  = (count_r != FULL);
   assign out_valid = (count_r != '0);
   assign push      = in_valid & in_ready;
   assign pop       = out_valid & out_ready;
   assign out_data  = mem_r[rd_ptr_r];
   assign level     = count_r;

   // storage write
   always_ff @(posedge pclk)
   begin
      if (push)
      begin
         mem_r[wr_ptr_r] <= in_data;
      end
   end

   // pointers wrap at depth, not at a power of two
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         wr_ptr_r <= '0;
         rd_ptr_r <= '0;
      end
      else
      begin
         if (push)
         begin
            wr_ptr_r <= (wr_ptr_r == LAST) ? '0 : wr_ptr_r + 1'b1;
         end
         if (pop)
         begin
            rd_ptr_r <= (rd_ptr_r == LAST) ? '0 : rd_ptr_r + 1'b1;
         end
      end
   end

   // occupancy
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         count_r <= '0;
      end
      else if (push && !pop)
      begin
         count_r <= count_r + 1'b1;
      end
      else if (pop && !push)
      begin
         count_r <= count_r - 1'b1;
      end
   end
endmodule // sample_fifo

// gain, mute and receive word control with apb registers
module voice_codec_gain_mute_control
   import codec_ctrl_pkg::*;
#(
   parameter int FIFO_DEPTH = 8
)
(
   input  wire logic               pclk,
   input  wire logic               presetn,
   input  wire logic               psel,
   input  wire logic               penable,
   input  wire logic               pwrite,
   input  wire logic [7:0]         paddr,
   input  wire logic [31:0]        pwdata,
   output logic [31:0]             prdata,
   output logic                    pready,
   output logic                    pslverr,
   input  wire logic               rx_bit_clk,
   input  wire logic               rx_frame_sync,
   input  wire logic               rx_serial_data,
   output logic [14:0]             sample_word,
   output logic                    sample_valid,
   input  wire logic               sample_ready,
   output logic signed [7:0]       tx_amp2_gain_half_db,
   output logic signed [7:0]       tx_pga_gain_half_db,
   output logic signed [7:0]       tx_total_gain_half_db,
   output logic [7:0]              tx_mute_atten_db,
   output logic signed [7:0]       rx_pga_gain_db,
   output logic signed [7:0]       sidetone_gain_db,
   output logic signed [7:0]       volume_gain_db,
   output logic                    microphone_mute,
   output logic                    sidetone_mute,
   output logic                    earphone_mute,
   output logic                    diff_earphone_amp_en,
   output logic                    single_earphone_amp_en,
   output logic                    linear_mode,
   output logic                    power_up
);
   localparam int LVW = $clog2(FIFO_DEPTH+1);

   generate
      if (FIFO_DEPTH < 2 || LVW > 4)
      begin : bad_depth
         $error("fifo depth must lie between 2 and 15");
      end
   endgenerate

   // address decode shared by write strobe and error answer
   function automatic logic addr_mapped(input logic [7:0] a);
      if (a == PWR_OFS || a == TX_GAIN_OFS || a == RX_GAIN_OFS || a == SIDE_OFS)
         addr_mapped = 1'b1;
      else if (a == VOLUME_OFS || a == MODE_OFS || a == STATUS_OFS || a == SAMPLE_OFS)
         addr_mapped = 1'b1;
      else
         addr_mapped = 1'b0;
   endfunction

   // transmit pga: low three bits step 2 db, capped at -10 db
   function automatic logic signed [7:0] tx_pga_decode(input logic [3:0] c);
      if (c[2:0] > 3'h5)
         tx_pga_decode = -8'sd20;
      else
         tx_pga_decode = -(8'(c[2:0]) <<< 2);
   endfunction

   // receive pga: +6 db at code 0, one db per step, floor -6 db
   function automatic logic signed [7:0] rx_pga_decode(input logic [3:0] c);
      if (c > 4'hc)
         rx_pga_decode = -8'sd6;
      else
         rx_pga_decode = 8'sd6 - 8'(c);
   endfunction

   // sidetone: -12 db at code 0, two db per step, floor -24 db
   function automatic logic signed [7:0] side_decode(input logic [2:0] c);
      if (c == 3'h7)
         side_decode = -8'sd24;
      else
         side_decode = -8'sd12 - (8'(c) <<< 1);
   endfunction

   // volume: 0 db at code 0, two db per step, floor -18 db
   function automatic logic signed [7:0] vol_decode(input logic [3:0] c);
      if (c > 4'h9)
         vol_decode = -8'sd18;
      else
         vol_decode = -(8'(c) <<< 1);
   endfunction

   logic [7:0]        pwr_r;
   logic [3:0]        tx_code_r;
   logic [3:0]        rx_code_r;
   logic [2:0]        side_code_r;
   logic [3:0]        vol_code_r;
   logic              linear_r;
   logic              overrun_r;
   logic [14:0]       last_word_r;
   logic [31:0]       prdata_r;
   logic              wr_acc;
   logic              setup;
   rx_state_type      rx_state_r;
   logic              bit_clk_q_r;
   logic              clk_fall;
   logic [14:0]       shift_r;
   logic [3:0]        bit_cnt_r;
   logic [3:0]        word_len;
   logic [14:0]       pend_word_r;
   logic              pend_valid_r;
   logic              fifo_in_ready;
   logic              word_done;
   logic [LVW-1:0]    fifo_level;
   logic signed [7:0] amp2_nxt;
   logic signed [7:0] pga_nxt;

   // zero-wait slave; error only on unmapped access phase
   assign pready  = 1'b1;
   assign pslverr = psel & penable & ~addr_mapped(paddr);
   assign prdata  = prdata_r;
   assign wr_acc  = psel & penable & pwrite & addr_mapped(paddr);
   assign setup   = psel & ~penable;

   // control registers, stored at the access edge of a write
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         pwr_r       <= PWR_RST;
         tx_code_r   <= TX_GAIN_RST;
         rx_code_r   <= RX_GAIN_RST;
         side_code_r <= SIDE_RST;
         vol_code_r  <= VOLUME_RST;
         linear_r    <= LINEAR_RST;
      end
      else if (wr_acc)
      begin
         if (paddr == PWR_OFS)
            pwr_r <= pwdata[7:0];
         else if (paddr == TX_GAIN_OFS)
            tx_code_r <= pwdata[3:0];
         else if (paddr == RX_GAIN_OFS)
            rx_code_r <= pwdata[3:0];
         else if (paddr == SIDE_OFS)
            side_code_r <= pwdata[2:0];
         else if (paddr == VOLUME_OFS)
            vol_code_r <= pwdata[3:0];
         else if (paddr == MODE_OFS)
            linear_r <= pwdata[LINEAR_BIT];
      end
   end

   // read data latched in the setup cycle, shown in the access phase
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         prdata_r <= '0;
      end
      else if (setup)
      begin
         prdata_r <= '0;
         if (paddr == PWR_OFS)
            prdata_r[7:0] <= pwr_r;
         else if (paddr == TX_GAIN_OFS)
            prdata_r[3:0] <= tx_code_r;
         else if (paddr == RX_GAIN_OFS)
            prdata_r[3:0] <= rx_code_r;
         else if (paddr == SIDE_OFS)
            prdata_r[2:0] <= side_code_r;
         else if (paddr == VOLUME_OFS)
            prdata_r[3:0] <= vol_code_r;
         else if (paddr == MODE_OFS)
            prdata_r[LINEAR_BIT] <= linear_r;
         else if (paddr == STATUS_OFS)
         begin
            prdata_r[OVERRUN_BIT]             <= overrun_r;
            prdata_r[BUSY_BIT]                <= (rx_state_r == RX_SHIFT);
            prdata_r[LEVEL_LSB +: LVW]        <= fifo_level;
         end
         else if (paddr == SAMPLE_OFS)
            prdata_r[14:0] <= last_word_r;
      end
   end

   // transmit mode split; undocumented codes clamp to the nearest step
   always_comb
   begin
      amp2_nxt = tx_code_r[3] ? 8'sd0 : MIC_AMP2_EXT_HALF_DB;
      pga_nxt  = tx_pga_decode(tx_code_r);
   end

   // settings applied one edge after the byte is stored
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         tx_amp2_gain_half_db  <= 8'sd0;
         tx_pga_gain_half_db   <= 8'sd0;
         tx_total_gain_half_db <= MIC_AMP1_HALF_DB;
         tx_mute_atten_db      <= 8'h00;
         rx_pga_gain_db        <= -8'sd1;
         sidetone_gain_db      <= -8'sd12;
         volume_gain_db        <= 8'sd0;
      end
      else
      begin
         tx_amp2_gain_half_db  <= amp2_nxt;
         tx_pga_gain_half_db   <= pga_nxt;
         tx_total_gain_half_db <= MIC_AMP1_HALF_DB + amp2_nxt + pga_nxt;
         tx_mute_atten_db      <= pwr_r[MIC_MUTE_BIT] ? MIC_MUTE_ATTEN_DB : 8'h00;
         rx_pga_gain_db        <= rx_pga_decode(rx_code_r);
         sidetone_gain_db      <= side_decode(side_code_r);
         volume_gain_db        <= vol_decode(vol_code_r);
      end
   end

   // mute and amplifier selection, applied after storage
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         microphone_mute        <= 1'b0;
         sidetone_mute          <= 1'b0;
         earphone_mute          <= 1'b0;
         diff_earphone_amp_en   <= 1'b0;
         single_earphone_amp_en <= 1'b1;
         linear_mode            <= LINEAR_RST;
         power_up               <= 1'b0;
      end
      else
      begin
         microphone_mute        <= pwr_r[MIC_MUTE_BIT];
         sidetone_mute          <= pwr_r[SIDETONE_MUTE_BIT];
         earphone_mute          <= pwr_r[EAR_MUTE_BIT];
         diff_earphone_amp_en   <= pwr_r[EAR_SEL_BIT];
         single_earphone_amp_en <= ~pwr_r[EAR_SEL_BIT];
         linear_mode            <= linear_r;
         power_up               <= pwr_r[PWR_UP_BIT];
      end
   end

   // bit clock falling edge, pins already synchronous
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         bit_clk_q_r <= 1'b0;
      else
         bit_clk_q_r <= rx_bit_clk;
   end

   assign clk_fall  = bit_clk_q_r & ~rx_bit_clk;
   assign word_len  = linear_r ? 4'(LINEAR_LEN) : 4'(COMPANDED_LEN);
   assign word_done = (rx_state_r == RX_SHIFT) && clk_fall && (bit_cnt_r + 1'b1 == word_len);

   // serial word shifter, most significant bit first
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         rx_state_r <= RX_IDLE;
         shift_r    <= '0;
         bit_cnt_r  <= '0;
      end
      else
      begin
         case (rx_state_r)
            RX_IDLE:
            begin
               if (clk_fall && rx_frame_sync)
               begin
                  shift_r    <= {14'h0000, rx_serial_data};
                  bit_cnt_r  <= 4'h1;
                  rx_state_r <= RX_SHIFT;
               end
            end
            RX_SHIFT:
            begin
               if (clk_fall)
               begin
                  shift_r   <= {shift_r[13:0], rx_serial_data};
                  bit_cnt_r <= bit_cnt_r + 1'b1;
                  if (word_done)
                     rx_state_r <= RX_IDLE;
               end
            end
            default:
               rx_state_r <= RX_IDLE;
         endcase
      end
   end

   // finished word waits here until the fifo takes it
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         pend_word_r  <= '0;
         pend_valid_r <= 1'b0;
         last_word_r  <= '0;
      end
      else if (word_done)
      begin
         pend_word_r  <= {shift_r[13:0], rx_serial_data};
         pend_valid_r <= 1'b1;
         last_word_r  <= {shift_r[13:0], rx_serial_data};
      end
      else if (fifo_in_ready)
      begin
         pend_valid_r <= 1'b0;
      end
   end

   // overrun is sticky; a new loss beats a write-one clear
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         overrun_r <= 1'b0;
      else if (word_done && pend_valid_r && !fifo_in_ready)
         overrun_r <= 1'b1;
      else if (wr_acc && paddr == STATUS_OFS && pwdata[OVERRUN_BIT])
         overrun_r <= 1'b0;
   end

   // receive data buffer toward the decoder
   sample_fifo #(
      .WIDTH (15),
      .DEPTH (FIFO_DEPTH)
   ) rx_fifo (
      .pclk      (pclk),
      .presetn   (presetn),
      .in_valid  (pend_valid_r),
      .in_ready  (fifo_in_ready),
      .in_data   (pend_word_r),
      .out_valid (sample_valid),
      .out_ready (sample_ready),
      .out_data  (sample_word),
      .level     (fifo_level)
   );
endmodule // voice_codec_gain_mute_control
